// *** hw/secp_defs.svh ***
// Constants of the serial EEPROM command and protect block.
// Included by the top design module, secp_top, only.
`ifndef SECP_DEFS_SVH
`define SECP_DEFS_SVH

// Opcodes, first byte after select falls
`define SECP_OP_EN_WR 8'h06
`define SECP_OP_DIS_WR 8'h04
`define SECP_OP_RD_ST 8'h05
`define SECP_OP_WR_ST 8'h01
`define SECP_OP_READ 8'h03
`define SECP_OP_WRITE 8'h02
`define SECP_OP_X_MASK 8'hF7
`define SECP_OP_X_BIT 3

// Status word layout
`define SECP_ST_BUSY 0
`define SECP_ST_LATCH 1
`define SECP_ST_PLO 2
`define SECP_ST_PHI 3
`define SECP_ST_ONES 4'hF

// Protect select codes and region bases
`define SECP_PROT_NONE 2'b00
`define SECP_PROT_QTR 2'b01
`define SECP_PROT_HALF 2'b10
`define SECP_PROT_ALL 2'b11
`define SECP_QTR_BASE 9'h180
`define SECP_HALF_BASE 9'h100

// Reset values
`define SECP_PROT_RST 2'b00
`define SECP_LATCH_RST 1'b0
`define SECP_PIN_RST 5'h13

// Array shape
`define SECP_MEM_DEPTH 512
`define SECP_PAGE_BYTES 16

// Timing
`define SECP_T_WC_MS 5
`define SECP_CLK_MHZ 250

`endif

// *** hw/secp_pkg.sv ***
// Types of the serial EEPROM command and protect block.
// Uses no macro from secp_defs.svh.
package secp_pkg;
  typedef logic [8:0] secp_addr_t;
  typedef logic [7:0] secp_byte_t;
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_CMD   = 8'h02,
    ST_ADDR  = 8'h04,
    ST_WDATA = 8'h08,
    ST_WSR   = 8'h10,
    ST_READ  = 8'h20,
    ST_READ_STATUS_CMD  = 8'h40,
    ST_SKIP  = 8'h80
  } secp_state_t;
endpackage

// *** hw/secp_sync.sv ***
// Two-stage synchroniser for a group of pin inputs.
// Inputs are asynchronous to clk; outputs are clk-domain levels.
`timescale 1ns/1ps
module secp_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// *** hw/secp_fifo.sv ***
// Small FIFO with valid/ready on both sides and a flush.
// Same clock on both sides.
`timescale 1ns/1ps
module secp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [CW-1:0] cnt_r;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (cnt_r != CW'(DEPTH)) & ~flush;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= ptr_inc(wp_r);
      if (pop) rp_r <= ptr_inc(rp_r);
      cnt_r <= CW'(cnt_r + CW'(push) - CW'(pop));
    end
  end
endmodule

// *** hw/secp_top.sv ***
// Serial EEPROM command, status and protection logic, device side.
// Pins come from an SPI host (modes 0 and 3) and are asynchronous to clk;
// clk must run well above the serial clock.
`timescale 1ns/1ps
`include "secp_defs.svh"
module secp_top #(
  parameter int unsigned WC_CYCLES = `SECP_T_WC_MS * 1000 * `SECP_CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so,
  output logic so_oe
);
  import secp_pkg::*;

  localparam int WC_W = $clog2(WC_CYCLES + 1);
  localparam int PG = `SECP_PAGE_BYTES;

  // ==========================================================
  // Pin synchronisation and edge detection
  // ==========================================================
  logic [4:0] pins_s;
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic hold_n_s;
  logic wp_n_s;
  logic sck_d_r;
  logic cs_d_r;

  secp_sync #(
    .WIDTH(5),
    .RST_VAL(`SECP_PIN_RST)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d({cs_n, sck, si, hold_n, wp_n}),
    .q(pins_s)
  );

  assign {cs_n_s, sck_s, si_s, hold_n_s, wp_n_s} = pins_s;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
      cs_d_r <= cs_n_s;
    end
  end

  wire sck_rise = sck_s & ~sck_d_r;
  wire sck_fall = ~sck_s & sck_d_r;
  wire cs_rise = cs_n_s & ~cs_d_r;
  // Held or deselected: serial clock edges do nothing
  wire active = ~cs_n_s & hold_n_s;
  wire rx_rise = active & sck_rise;
  wire tx_fall = active & sck_fall;

  // ==========================================================
  // Receive shifter
  // ==========================================================
  logic [6:0] rx_sh_r;
  logic [2:0] bit_cnt_r;

  wire byte_done = rx_rise & (bit_cnt_r == 3'h7);
  wire [7:0] rx_byte = {rx_sh_r, si_s};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_sh_r <= 7'h00;
      bit_cnt_r <= 3'h0;
    end else if (cs_n_s) begin
      bit_cnt_r <= 3'h0;
    end else if (rx_rise) begin
      rx_sh_r <= rx_byte[6:0];
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  // ==========================================================
  // Status and opcode decode
  // ==========================================================
  secp_state_t state_r;
  secp_state_t state_nxt;
  logic busy_r;
  logic wel_r;
  logic [1:0] prot_r;
  logic [WC_W-1:0] wc_cnt_r;

  wire [7:0] status_word = {`SECP_ST_ONES, prot_r, wel_r, busy_r};

  wire op_en = (rx_byte == `SECP_OP_EN_WR);
  wire op_dis = (rx_byte == `SECP_OP_DIS_WR);
  wire op_rs = (rx_byte == `SECP_OP_RD_ST);
  wire op_ws = (rx_byte == `SECP_OP_WR_ST);
  wire op_rd = ((rx_byte & `SECP_OP_X_MASK) == `SECP_OP_READ);
  wire op_wr = ((rx_byte & `SECP_OP_X_MASK) == `SECP_OP_WRITE);

  wire cmd_done = byte_done & (state_r == ST_CMD);
  // Busy lets only read-status through
  wire cmd_ok = cmd_done & ~busy_r;

  // Address inside the protected region for a select code
  function automatic logic is_prot(input secp_addr_t a, input logic [1:0] p);
    case (p)
      `SECP_PROT_QTR: is_prot = (a >= `SECP_QTR_BASE);
      `SECP_PROT_HALF: is_prot = (a >= `SECP_HALF_BASE);
      `SECP_PROT_ALL: is_prot = 1'b1;
      default: is_prot = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Session state machine
  // ==========================================================
  logic cmd_rd_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (!cs_n_s) state_nxt = ST_CMD;
      end
      ST_CMD: begin
        if (cmd_done) begin
          if (op_rs) state_nxt = ST_READ_STATUS_CMD;
          else if (busy_r) state_nxt = ST_SKIP;
          else if (op_rd || op_wr) state_nxt = ST_ADDR;
          else if (op_ws) state_nxt = ST_WSR;
          else state_nxt = ST_SKIP;
        end
      end
      ST_ADDR: begin
        if (byte_done) state_nxt = cmd_rd_r ? ST_READ : ST_WDATA;
      end
      default: state_nxt = state_r;
    endcase
    if (cs_n_s) state_nxt = ST_IDLE;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) state_r <= ST_IDLE;
    else state_r <= state_nxt;
  end

  // ==========================================================
  // Address capture
  // ==========================================================
  secp_addr_t addr_r;
  secp_addr_t rd_ptr_r;
  logic fill_take;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_rd_r <= 1'b0;
      addr_r <= 9'h000;
    end else if (cmd_ok) begin
      cmd_rd_r <= op_rd;
      addr_r[8] <= rx_byte[`SECP_OP_X_BIT];
    end else if (byte_done && state_r == ST_ADDR) begin
      addr_r[7:0] <= rx_byte;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ptr_r <= 9'h000;
    end else if (byte_done && state_r == ST_ADDR) begin
      rd_ptr_r <= {addr_r[8], rx_byte};
    end else if (fill_take && state_r == ST_READ) begin
      rd_ptr_r <= rd_ptr_r + 9'h001;
    end
  end

  // ==========================================================
  // Page load buffer and status write value
  // ==========================================================
  logic [7:0] pg_data_r [PG];
  logic [PG-1:0] pg_mask_r;
  logic [3:0] pg_off_r;
  logic [1:0] ws_val_r;
  logic ws_got_r;

  wire load_byte = byte_done & (state_r == ST_WDATA);

  always_ff @(posedge clk) begin
    if (load_byte) pg_data_r[pg_off_r] <= rx_byte;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pg_mask_r <= '0;
      pg_off_r <= 4'h0;
    end else if (cmd_ok) begin
      pg_mask_r <= '0;
    end else if (byte_done && state_r == ST_ADDR) begin
      pg_off_r <= rx_byte[3:0];
    end else if (load_byte) begin
      pg_mask_r[pg_off_r] <= 1'b1;
      // Four-bit offset wraps inside the page
      pg_off_r <= pg_off_r + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ws_val_r <= 2'b00;
      ws_got_r <= 1'b0;
    end else if (cmd_ok) begin
      ws_got_r <= 1'b0;
    end else if (byte_done && state_r == ST_WSR) begin
      ws_val_r <= rx_byte[`SECP_ST_PHI:`SECP_ST_PLO];
      ws_got_r <= 1'b1;
    end
  end

  // ==========================================================
  // Write protect tracking and commit decision
  // ==========================================================
  logic wp_abort_r;
  logic en_pend_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) wp_abort_r <= 1'b0;
    else if (state_r == ST_IDLE) wp_abort_r <= 1'b0;
    else if (!wp_n_s) wp_abort_r <= 1'b1;
  end

  wire wp_block = wp_abort_r | ~wp_n_s;
  wire whole = (bit_cnt_r == 3'h0);
  wire secp_addr_t page_base = {addr_r[8:4], 4'h0};
  // Region bases are page aligned, so the page base decides
  wire pg_free = ~is_prot(page_base, prot_r);

  wire go_mem = cs_rise & (state_r == ST_WDATA) & (|pg_mask_r) & whole
    & wel_r & ~wp_block & pg_free;
  wire go_ws = cs_rise & (state_r == ST_WSR) & ws_got_r & whole
    & wel_r & ~wp_block;
  wire wc_done = busy_r & (wc_cnt_r == WC_W'(WC_CYCLES - 1));

  // ==========================================================
  // Internal write cycle
  // ==========================================================
  logic [7:0] mem_r [`SECP_MEM_DEPTH];
  logic ws_is_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      wc_cnt_r <= '0;
    end else if (go_mem || go_ws) begin
      busy_r <= 1'b1;
      wc_cnt_r <= '0;
    end else if (wc_done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      // Runs regardless of the protect pin
      wc_cnt_r <= wc_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) ws_is_r <= 1'b0;
    else if (go_mem || go_ws) ws_is_r <= go_ws;
  end

  always_ff @(posedge clk) begin
    if (go_mem) begin
      for (int i = 0; i < PG; i++) begin
        if (pg_mask_r[i]) mem_r[{addr_r[8:4], 4'(i)}] <= pg_data_r[i];
      end
    end
  end

  // Protect selects take the new code when the status cycle ends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) prot_r <= `SECP_PROT_RST;
    else if (wc_done && ws_is_r) prot_r <= ws_val_r;
  end

  // ==========================================================
  // Write latch
  // ==========================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) en_pend_r <= 1'b0;
    else if (state_r == ST_IDLE) en_pend_r <= 1'b0;
    else if (cmd_ok && op_en) en_pend_r <= 1'b1;
    else if (rx_rise) en_pend_r <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wel_r <= `SECP_LATCH_RST;
    end else if (cs_rise && en_pend_r) begin
      wel_r <= 1'b1;
    end else if (wc_done) begin
      wel_r <= 1'b0;
    end else if (cmd_ok && op_dis) begin
      wel_r <= 1'b0;
    end
  end

  // ==========================================================
  // Read data path through the two-entry buffer
  // ==========================================================
  logic fill_ready;
  logic drain_valid;
  logic [7:0] drain_data;
  logic [6:0] ob_sh_r;
  logic [2:0] ob_cnt_r;
  logic so_r;

  wire out_on = (state_r == ST_READ) | (state_r == ST_READ_STATUS_CMD);
  wire [7:0] fill_data = (state_r == ST_READ_STATUS_CMD) ? status_word : mem_r[rd_ptr_r];
  wire drain_take = tx_fall & out_on & (ob_cnt_r == 3'h0);

  assign fill_take = out_on & fill_ready;

  secp_fifo #(
    .WIDTH(8),
    .DEPTH(2)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .flush(~out_on),
    .in_valid(out_on),
    .in_ready(fill_ready),
    .in_data(fill_data),
    .out_valid(drain_valid),
    .out_ready(drain_take),
    .out_data(drain_data)
  );

  // Empty buffer at a byte boundary sends zeros
  wire [7:0] next_byte = drain_valid ? drain_data : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ob_sh_r <= 7'h00;
      ob_cnt_r <= 3'h0;
      so_r <= 1'b0;
    end else if (!out_on) begin
      ob_cnt_r <= 3'h0;
    end else if (drain_take) begin
      so_r <= next_byte[7];
      ob_sh_r <= next_byte[6:0];
      ob_cnt_r <= 3'h7;
    end else if (tx_fall) begin
      so_r <= ob_sh_r[6];
      ob_sh_r <= {ob_sh_r[5:0], 1'b0};
      ob_cnt_r <= ob_cnt_r - 3'h1;
    end
  end

  // ==========================================================
  // Serial output pin
  // ==========================================================
  assign so = so_r;
  assign so_oe = out_on & ~cs_n_s & hold_n_s;

endmodule

// *** dv/secp_checker.sv ***
// Port-level assertions on the serial output of secp_top.
// Bound to secp_top below; sees only its pins, clk at 250 MHz.
`timescale 1ns/1ps
module secp_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic hold_n,
  input wire logic so,
  input wire logic so_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ==========================================
  // Output enable
  chk_oe_off_idle: assert property (cs_n [*4] |-> !so_oe)
    else $error("so_oe high while deselected");
  chk_oe_drop_cs: assert property ($rose(cs_n) |-> ##[1:4] !so_oe)
    else $error("so_oe not released after select rise");
  chk_oe_drop_hold: assert property ($fell(hold_n) |-> ##[1:4] !so_oe)
    else $error("so_oe not released after hold");
  chk_oe_low_held: assert property (!hold_n [*4] |-> !so_oe)
    else $error("so_oe high during hold");
  chk_oe_needs_sel: assert property (so_oe |-> !$past(cs_n, 2) && $past(hold_n, 2))
    else $error("so_oe high without select and hold released");
  chk_oe_rise_sck: assert property ($rose(so_oe) && $past(hold_n, 6) |-> sck)
    else $error("so_oe rose outside the last rising clock phase");

  // ==========================================
  // Serial data timing
  chk_so_quiet_high: assert property (sck [*4] |-> $stable(so))
    else $error("so changed during serial clock high");
  chk_so_spacing: assert property ($changed(so) |=> $stable(so) [*4])
    else $error("so changed twice within one clock phase");
endmodule

bind secp_top secp_checker chk (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .hold_n(hold_n),
  .so(so), .so_oe(so_oe));

// *** dv/secp_host.sv ***
// SPI host model (mode 0, or mode 3 with cpol high) driving select, clock, data, hold.
// Changes pins at the falling clk edge; sck period is 12 clk (48 ns).
`timescale 1ns/1ps
module secp_host (
  input wire logic clk,
  input wire logic cpol,
  input wire logic so,
  input wire logic so_oe,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Select 0 opens a session, 1 ends it
  task automatic sel(input logic v);
    // Clock rests at the mode's idle level before select falls
    if (!v) sck = cpol;
    idle(4);
    cs_n = v;
    idle(4);
  endtask

  // Shifts n bits MSB first; so sampled at each rising sck
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      if (cpol) sck = 1'b0;
      si = tx[i];
      idle(6);
      sck = 1'b1;
      rx[i] = so_oe ? so : 1'bz;
      idle(6);
      if (!cpol) sck = 1'b0;
    end
    si = ~si;
  endtask

  // Pause with sck low at both hold edges; noise on sck and si meanwhile
  task automatic pause(input int n);
    // Device must see the last falling edge before the hold
    idle(6);
    hold_n = 1'b0;
    for (int i = 0; i < 2 * n; i++) begin
      si = ~si;
      idle(6);
      sck = ~sck;
    end
    idle(6);
    hold_n = 1'b1;
    idle(6);
  endtask
endmodule

// *** dv/tb_spi_eeprom_cmd_protect.sv ***
// Self-checking bench for secp_top driven through the host model.
// Needs secp_pkg and secp_defs.svh; write cycle shortened to 400 clk.
`timescale 1ns/1ps
module tb_spi_eeprom_cmd_protect;
  import secp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic cpol = 1'b0;
  logic cs_n, sck, si, hold_n, so, so_oe;
  int miscompares = 0;
  int check_count = 0;
  secp_byte_t mem_m [512];
  secp_byte_t rx;

`define CHK(n, e, g) begin \
    check_count++; \
    if ((g) !== (e)) begin \
      miscompares++; \
      $display("[FAIL] %s expected %h seen %h", n, (e), (g)); \
    end \
  end

  always #2 clk = ~clk;

  secp_top #(.WC_CYCLES(400)) uut (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe));
  secp_host host (.clk(clk), .cpol(cpol), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n));

  // ==========================================
  // Expectations
  function automatic secp_byte_t st_exp(logic [1:0] p, logic l, logic b);
    return {4'hF, p, l, b};
  endfunction
  function automatic logic hit(logic [1:0] p, secp_addr_t a);
    return p == 2'h3 || (p == 2'h2 && a[8]) || (p == 2'h1 && a[8:7] == 2'h3);
  endfunction

  // ==========================================
  // Sessions
  task automatic test_done();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic op(input secp_byte_t b);
    host.sel(1'b0);
    host.xfer(b, 8, rx);
    host.sel(1'b1);
  endtask
  task automatic read_status_cmd(output secp_byte_t s);
    host.sel(1'b0);
    host.xfer(8'h05, 8, s);
    host.xfer(8'h00, 8, s);
    host.sel(1'b1);
  endtask
  task automatic wait_ready();
    secp_byte_t s;
    int n;
    s = 8'h01;
    n = 0;
    while (s[0] !== 1'b0) begin
      if (n == 20) begin
        miscompares++;
        test_done();
      end
      read_status_cmd(s);
      n++;
    end
  endtask
  task automatic wr(input secp_addr_t a, input int n, input int bits, input logic en,
                    input logic drop, input logic ok, output secp_byte_t s);
    secp_byte_t d;
    if (en) op(8'h06);
    host.sel(1'b0);
    host.xfer({4'h0, a[8], 3'h2}, 8, rx);
    host.xfer(a[7:0], 8, rx);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      host.xfer(d, 8, rx);
      if (ok) mem_m[{a[8:4], a[3:0] + 4'(i)}] = d;
    end
    host.xfer(8'($urandom), bits, rx);
    // Protect pin pulses low and recovers while select is still low
    if (drop) begin
      wp_n = 1'b0;
      host.idle(6);
      wp_n = 1'b1;
    end
    host.sel(1'b1);
    read_status_cmd(s);
  endtask
  task automatic rd(input secp_addr_t a, input int n);
    host.sel(1'b0);
    host.xfer({4'h0, a[8], 3'h3}, 8, rx);
    host.xfer(a[7:0], 8, rx);
    for (int i = 0; i < n; i++) begin
      host.xfer(8'($urandom), 8, rx);
      `CHK("read data", mem_m[9'(a + i)], rx)
    end
    host.sel(1'b1);
  endtask
  task automatic write_status_cmd(input logic [1:0] p);
    secp_byte_t d;
    d = 8'($urandom);
    op(8'h06);
    host.sel(1'b0);
    host.xfer(8'h01, 8, rx);
    host.xfer({d[7:4], p, d[1:0]}, 8, rx);
    host.sel(1'b1);
    wait_ready();
  endtask

  // ==========================================
  // Main sequence
  initial begin
    secp_byte_t s;
    secp_addr_t a;
    void'($urandom(32041));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    read_status_cmd(s);
    `CHK("reset status", st_exp(2'h0, 1'b0, 1'b0), s)
    wr(9'h010, 1, 0, 1'b0, 1'b0, 1'b0, s);
    `CHK("write without latch", st_exp(2'h0, 1'b0, 1'b0), s)
    op(8'h06);
    read_status_cmd(s);
    `CHK("latch set", st_exp(2'h0, 1'b1, 1'b0), s)
    op(8'h04);
    read_status_cmd(s);
    `CHK("latch clear", st_exp(2'h0, 1'b0, 1'b0), s)
    host.sel(1'b0);
    host.xfer(8'h06, 8, rx);
    host.xfer(8'h00, 1, rx);
    host.sel(1'b1);
    read_status_cmd(s);
    `CHK("latch after extra clock", st_exp(2'h0, 1'b0, 1'b0), s)
    op(8'($urandom) | 8'h80);
    host.sel(1'b0);
    host.xfer(8'($urandom) | 8'h80, 8, rx);
    host.xfer(8'h00, 8, rx);
    host.sel(1'b1);
    `CHK("unknown opcode output", 8'hzz, rx)
    host.sel(1'b0);
    host.xfer(8'h05, 4, rx);
    host.pause(3);
    host.xfer(8'h50, 4, rx);
    host.xfer(8'($urandom), 4, rx);
    `CHK("status high nibble", 4'hF, rx[7:4])
    host.pause(2);
    host.xfer(8'($urandom), 4, rx);
    `CHK("status low nibble across hold", 4'h0, rx[7:4])
    host.xfer(8'h00, 8, s);
    host.sel(1'b1);
    `CHK("status across hold", st_exp(2'h0, 1'b0, 1'b0), s)
    for (int k = 0; k < 4; k++) begin
      // Odd passes run the link in mode 3
      cpol = k[0];
      a = (k == 0) ? 9'h0A7 : 9'($urandom);
      wr(a, (k == 0) ? 16 : 1 + $urandom % 16, 0, 1'b1, 1'b0, 1'b1, s);
      `CHK("busy after write", st_exp(2'h0, 1'b1, 1'b1), s)
      host.sel(1'b0);
      host.xfer(8'h03, 8, rx);
      host.xfer(8'($urandom), 8, rx);
      host.xfer(8'($urandom), 8, rx);
      host.sel(1'b1);
      `CHK("read during busy", 8'hzz, rx)
      wait_ready();
      read_status_cmd(s);
      `CHK("status after cycle", st_exp(2'h0, 1'b0, 1'b0), s)
      rd({a[8:4], 4'h0}, 16);
    end
    cpol = 1'b0;
    for (int j = 0; j < 2; j++) begin
      wr(j ? 9'h000 : 9'h1FF, 1, 0, 1'b1, 1'b0, 1'b1, s);
      wait_ready();
    end
    rd(9'h1FF, 2);
    wr(9'h020, 1, 4, 1'b1, 1'b0, 1'b0, s);
    `CHK("partial byte write", 1'b0, s[0])
    for (int p = 1; p < 4; p++) begin
      write_status_cmd(2'(p));
      read_status_cmd(s);
      `CHK("status write", st_exp(2'(p), 1'b0, 1'b0), s)
      for (int j = 0; j < 2; j++) begin
        a = (p == 1 ? 9'h180 : p == 2 ? 9'h100 : 9'h000) - 9'(j);
        wr(a, 1, 0, 1'b1, 1'b0, !hit(2'(p), a), s);
        `CHK("protected write", !hit(2'(p), a), s[0])
        if (s[0]) wait_ready();
      end
    end
    write_status_cmd(2'h0);
    wp_n = 1'b0;
    wr(9'h030, 1, 0, 1'b1, 1'b0, 1'b0, s);
    `CHK("write under protect pin", 1'b0, s[0])
    write_status_cmd(2'h3);
    read_status_cmd(s);
    `CHK("status write under protect pin", 2'h0, s[3:2])
    wp_n = 1'b1;
    wr(9'h040, 1, 0, 1'b1, 1'b1, 1'b0, s);
    `CHK("protect pin fall in session", 1'b0, s[0])
    wp_n = 1'b1;
    wr(9'h050, 1, 0, 1'b1, 1'b0, 1'b1, s);
    `CHK("busy before protect pin fall", 1'b1, s[0])
    wp_n = 1'b0;
    wait_ready();
    wp_n = 1'b1;
    rd(9'h050, 1);
    test_done();
  end
endmodule
